// ---- comparator_event_consts.vh ----
// Constants for the comparator event control block
`ifndef COMPARATOR_EVENT_CONSTS_VH
`define COMPARATOR_EVENT_CONSTS_VH
`define CMP_COUNT 2
`define CMP_GLOBAL_DISABLE_BIT 5
`define CMP_SETTLE_TIME_US 10
`define CMP_CLOCK_MHZ 250
`define CMP_SETTLE_CYCLES (`CMP_SETTLE_TIME_US * `CMP_CLOCK_MHZ)
`define CMP_SETTLE_WIDTH 12
`define CMP_SETTLE_LAST 12'h9c3
`define CMP_FLAG_RESET 1'b0
`define CMP_SEL_PIN 1'b0
`define CMP_SEL_REF 1'b1
`endif

// ---- cmp_result_sync.v ----
// Three-stage synchroniser and change detector for one comparator result
`timescale 1ns/1ps
module cmp_result_sync (
	input wire clock,
	input wire rst_n,
	input wire active,
	input wire raw_in,
	output reg result_q,
	output wire change
);
	reg meta_q;
	reg s2_q;
	reg s3_q;
	reg valid_q;
	always @(posedge clock) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			result_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			meta_q <= raw_in;
			s2_q <= meta_q;
			s3_q <= s2_q;
			if (!active) begin
				valid_q <= 1'b0;
				result_q <= 1'b0;
			end else if (s2_q == s3_q) begin
				result_q <= s3_q;
				valid_q <= 1'b1;
			end
		end
	end
	// A change counts once two stages agree on a new level
	assign change = active && valid_q && (s2_q == s3_q) && (s3_q != result_q);
endmodule // cmp_result_sync

// ---- cmp_change_flag.v ----
// Sticky change flag with set-over-clear priority
`timescale 1ns/1ps
`include "comparator_event_consts.vh"
module cmp_change_flag (
	input wire clock,
	input wire rst_n,
	input wire set,
	input wire clear,
	output reg flag_q
);
	always @(posedge clock) begin
		if (!rst_n) begin
			flag_q <= `CMP_FLAG_RESET;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clear) begin
			flag_q <= 1'b0;
		end
	end
endmodule // cmp_change_flag

// ---- comparator_event_control.v ----
// Control and event logic for two analog comparators
// Summary of operation
// - Result is one when positive exceeds negative
// - Negative input selectable: pin or reference
// - Each comparator may interrupt on change
// - Only comparator one routes to pin
// - Change of result sets sticky flag
// - Both interrupts share one vector
// - Comparators keep running in Idle/Power-down
// - Total Power-down disables both comparators
// - Enabled change interrupts and wakes processor
// - Control register bit 5 disables comparators
`timescale 1ns/1ps
`include "comparator_event_consts.vh"
module comparator_event_control (
	input wire clock,
	input wire rst_n,
	input wire [1:0] cmp_enable,
	input wire [1:0] neg_sel,
	input wire [1:0] int_enable,
	input wire [1:0] flag_clear,
	input wire out_pin_enable,
	input wire [7:0] power_ctrl_reg_a,
	input wire idle_mode,
	input wire power_down_mode,
	input wire total_power_down,
	input wire [1:0] cmp_raw,
	output reg [1:0] analog_enable_q,
	output reg [1:0] neg_sel_q,
	output reg [1:0] result_q,
	output wire [1:0] change_flag,
	output reg [1:0] settled_q,
	output reg cmp_out_pin_q,
	output reg cmp_out_pin_oe_n_q,
	output wire irq,
	output wire wake
);
	// Gating and synchroniser outputs
	wire global_off;
	wire [1:0] active;
	wire [1:0] sync_result;
	wire [1:0] change;
	wire [1:0] flag_set;
	wire [1:0] flag_clr;
	wire [1:0] irq_source;
	wire irq_any;
	wire low_power;
	wire [1:0] settle_done;

	// Settling counters
	reg [`CMP_SETTLE_WIDTH-1:0] settle0_q;
	reg [`CMP_SETTLE_WIDTH-1:0] settle0_d;
	reg [`CMP_SETTLE_WIDTH-1:0] settle1_q;
	reg [`CMP_SETTLE_WIDTH-1:0] settle1_d;

	// Next values of the output registers
	reg [1:0] analog_enable_d;
	reg [1:0] neg_sel_d;
	reg [1:0] result_d;
	reg [1:0] settled_d;
	reg cmp_out_pin_d;
	reg cmp_out_pin_oe_n_d;

	// Idle and Power-down do not gate the comparators; only these do
	assign global_off = power_ctrl_reg_a[`CMP_GLOBAL_DISABLE_BIT] | total_power_down;
	assign active[0] = cmp_enable[0] & ~global_off;
	assign active[1] = cmp_enable[1] & ~global_off;

	// Flag set and clear requests
	assign flag_set[0] = change[0];
	assign flag_set[1] = change[1];
	assign flag_clr[0] = flag_clear[0];
	assign flag_clr[1] = flag_clear[1];

	// Comparator one: synchroniser and change flag
	cmp_result_sync u_sync0 (
		.clock(clock),
		.rst_n(rst_n),
		.active(active[0]),
		.raw_in(cmp_raw[0]),
		.result_q(sync_result[0]),
		.change(change[0])
	);

	cmp_change_flag u_flag0 (
		.clock(clock),
		.rst_n(rst_n),
		.set(flag_set[0]),
		.clear(flag_clr[0]),
		.flag_q(change_flag[0])
	);

	// Comparator two: synchroniser and change flag
	cmp_result_sync u_sync1 (
		.clock(clock),
		.rst_n(rst_n),
		.active(active[1]),
		.raw_in(cmp_raw[1]),
		.result_q(sync_result[1]),
		.change(change[1])
	);

	cmp_change_flag u_flag1 (
		.clock(clock),
		.rst_n(rst_n),
		.set(flag_set[1]),
		.clear(flag_clr[1]),
		.flag_q(change_flag[1])
	);

	// Analog core enables follow the gated enables
	always @* begin
		analog_enable_d = 2'h0;
		if (!global_off) begin
			analog_enable_d[0] = cmp_enable[0];
			analog_enable_d[1] = cmp_enable[1];
		end
	end

	// Comparator one core enable
	always @(posedge clock) begin
		if (!rst_n) begin
			analog_enable_q[0] <= 1'b0;
		end else begin
			analog_enable_q[0] <= analog_enable_d[0];
		end
	end

	// Comparator two core enable
	always @(posedge clock) begin
		if (!rst_n) begin
			analog_enable_q[1] <= 1'b0;
		end else begin
			analog_enable_q[1] <= analog_enable_d[1];
		end
	end

	// Negative input select: pin or internal reference
	always @* begin
		neg_sel_d = {2{`CMP_SEL_PIN}};
		if (neg_sel[0] == `CMP_SEL_REF) begin
			neg_sel_d[0] = `CMP_SEL_REF;
		end
		if (neg_sel[1] == `CMP_SEL_REF) begin
			neg_sel_d[1] = `CMP_SEL_REF;
		end
	end

	// Comparator one input select
	always @(posedge clock) begin
		if (!rst_n) begin
			neg_sel_q[0] <= `CMP_SEL_PIN;
		end else begin
			neg_sel_q[0] <= neg_sel_d[0];
		end
	end

	// Comparator two input select
	always @(posedge clock) begin
		if (!rst_n) begin
			neg_sel_q[1] <= `CMP_SEL_PIN;
		end else begin
			neg_sel_q[1] <= neg_sel_d[1];
		end
	end

	// Synchronised results, forced low while inactive
	always @* begin
		result_d = 2'h0;
		if (active[0]) begin
			result_d[0] = sync_result[0];
		end
		if (active[1]) begin
			result_d[1] = sync_result[1];
		end
	end

	// Comparator one result
	always @(posedge clock) begin
		if (!rst_n) begin
			result_q[0] <= 1'b0;
		end else begin
			result_q[0] <= result_d[0];
		end
	end

	// Comparator two result
	always @(posedge clock) begin
		if (!rst_n) begin
			result_q[1] <= 1'b0;
		end else begin
			result_q[1] <= result_d[1];
		end
	end

	// Settling window of comparator one
	always @* begin
		settle0_d = settle0_q;
		// Hold at the last count
		if (!active[0]) begin
			settle0_d = {`CMP_SETTLE_WIDTH{1'b0}};
		end else if (settle0_q != `CMP_SETTLE_LAST) begin
			settle0_d = settle0_q + 1'b1;
		end
	end

	// Settling window of comparator two
	always @* begin
		settle1_d = settle1_q;
		// Hold at the last count
		if (!active[1]) begin
			settle1_d = {`CMP_SETTLE_WIDTH{1'b0}};
		end else if (settle1_q != `CMP_SETTLE_LAST) begin
			settle1_d = settle1_q + 1'b1;
		end
	end

	// Comparator one settle counter
	always @(posedge clock) begin
		if (!rst_n) begin
			settle0_q <= {`CMP_SETTLE_WIDTH{1'b0}};
		end else begin
			settle0_q <= settle0_d;
		end
	end

	// Comparator two settle counter
	always @(posedge clock) begin
		if (!rst_n) begin
			settle1_q <= {`CMP_SETTLE_WIDTH{1'b0}};
		end else begin
			settle1_q <= settle1_d;
		end
	end

	// Window complete while still active
	assign settle_done[0] = active[0] & (settle0_q == `CMP_SETTLE_LAST);
	assign settle_done[1] = active[1] & (settle1_q == `CMP_SETTLE_LAST);

	// Status bits that tell software the window has passed
	always @* begin
		settled_d = 2'h0;
		if (settle_done[0]) begin
			settled_d[0] = 1'b1;
		end
		if (settle_done[1]) begin
			settled_d[1] = 1'b1;
		end
	end

	// Comparator one settled status
	always @(posedge clock) begin
		if (!rst_n) begin
			settled_q[0] <= 1'b0;
		end else begin
			settled_q[0] <= settled_d[0];
		end
	end

	// Comparator two settled status
	always @(posedge clock) begin
		if (!rst_n) begin
			settled_q[1] <= 1'b0;
		end else begin
			settled_q[1] <= settled_d[1];
		end
	end

	// Output pin carries comparator one only
	always @* begin
		cmp_out_pin_d = 1'b0;
		cmp_out_pin_oe_n_d = 1'b1;
		if (out_pin_enable && active[0]) begin
			cmp_out_pin_d = sync_result[0];
			cmp_out_pin_oe_n_d = 1'b0;
		end
	end

	// Pin level
	always @(posedge clock) begin
		if (!rst_n) begin
			cmp_out_pin_q <= 1'b0;
		end else begin
			cmp_out_pin_q <= cmp_out_pin_d;
		end
	end

	// Pin driver enable, low while driving
	always @(posedge clock) begin
		if (!rst_n) begin
			cmp_out_pin_oe_n_q <= 1'b1;
		end else begin
			cmp_out_pin_oe_n_q <= cmp_out_pin_oe_n_d;
		end
	end

	// Shared vector; software reads the flags to find the source
	assign irq_source[0] = change_flag[0] & int_enable[0];
	assign irq_source[1] = change_flag[1] & int_enable[1];
	assign irq_any = irq_source[0] | irq_source[1];
	assign irq = irq_any & ~total_power_down;
	// Wake only matters in the reduced-power modes
	assign low_power = idle_mode | power_down_mode;
	assign wake = irq & low_power;
endmodule // comparator_event_control

// ---- cmp_ev_properties.sv ----
// Assertions for the comparator event control block
`timescale 1ns/1ps
module cmp_ev_properties (input wire clock, rst_n, idle_mode, power_down_mode, total_power_down,
	input wire out_pin_enable, cmp_out_pin_oe_n_q, irq, wake, input wire [7:0] power_ctrl_reg_a,
	input wire [1:0] cmp_enable, int_enable, flag_clear, cmp_raw, analog_enable_q, change_flag);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_en; $past(rst_n) |-> analog_enable_q ==
		$past(cmp_enable & ~{2{power_ctrl_reg_a[5] | total_power_down}}); endproperty
	a_en: assert property (p_en) else $error("Bad enable");
	property p_tpd; total_power_down |=> analog_enable_q == 2'h0; endproperty
	a_tpd: assert property (p_tpd) else $error("Live in deep sleep");
	property p_off; power_ctrl_reg_a[5] |=> analog_enable_q == 2'h0; endproperty
	a_off: assert property (p_off) else $error("Live when disabled");
	property p_irq; irq == (|(change_flag & int_enable) && !total_power_down); endproperty
	a_irq: assert property (p_irq) else $error("Bad irq");
	property p_wake; wake == (irq && (idle_mode || power_down_mode)); endproperty
	a_wake: assert property (p_wake) else $error("Bad wake");
	property p_hold; change_flag[0] && !flag_clear[0] |=> change_flag[0]; endproperty
	a_hold: assert property (p_hold) else $error("Flag lost");
	property p_pin; out_pin_enable && cmp_enable[0] && !power_ctrl_reg_a[5] && !total_power_down
		|=> !cmp_out_pin_oe_n_q; endproperty
	a_pin: assert property (p_pin) else $error("Pin not driven");
	property p_edge; $rose(change_flag[0]) |-> $past(cmp_raw[0], 3) != $past(cmp_raw[0], 6); endproperty
	a_edge: assert property (p_edge) else $error("Spurious flag");
	c_irq: cover property ($rose(irq));
	c_wake: cover property ($rose(wake));
	c_tpd: cover property (total_power_down);
endmodule // cmp_ev_properties

// ---- tb_comparator_event_control.sv ----
// Testbench for the comparator event control block
`timescale 1ns/1ps
module tb_comparator_event_control;
	reg clock, rst_n, out_pin_enable, idle_mode, power_down_mode, total_power_down;
	reg [1:0] cmp_enable, neg_sel, int_enable, flag_clear, cmp_raw;
	reg [7:0] power_ctrl_reg_a;
	wire [1:0] analog_enable_q, neg_sel_q, result_q, change_flag, settled_q;
	wire cmp_out_pin_q, cmp_out_pin_oe_n_q, irq, wake;
	integer err_total = 0;
	integer checks = 0;
	comparator_event_control dut (.*);
	task cyc(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task ck(input [7:0] got, input [7:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task t_flag;
		cmp_enable = 2'h3;
		cyc(2510);
		ck(settled_q, 2'h3);
		cmp_raw = 2'h1;
		cyc(8);
		ck(change_flag, 2'h1);
		ck(result_q, 2'h1);
		flag_clear = 2'h1;
		cyc(1);
		flag_clear = 2'h0;
		int_enable = 2'h1;
		idle_mode = 1'h1;
		cmp_raw = 2'h0;
		cyc(8);
		ck(wake, 1'h1);
		flag_clear = 2'h1;
		cyc(1);
		flag_clear = 2'h0;
		int_enable = 2'h2;
		cmp_raw = 2'h2;
		cyc(8);
		ck({irq, change_flag}, 3'h6);
		$display("t_flag done");
	endtask
	task t_pwr;
		power_ctrl_reg_a = 8'h20;
		cyc(2);
		ck(analog_enable_q, 2'h0);
		power_ctrl_reg_a = 8'h00;
		total_power_down = 1'h1;
		cyc(2);
		ck({irq, analog_enable_q}, 3'h0);
		total_power_down = 1'h0;
		power_down_mode = 1'h1;
		cyc(2);
		ck(analog_enable_q, 2'h3);
		$display("t_pwr done");
	endtask
	task t_pin;
		out_pin_enable = 1'h1;
		neg_sel = 2'h2;
		cmp_raw = 2'h1;
		cyc(3);
		flag_clear = 2'h2;
		cyc(1);
		flag_clear = 2'h0;
		ck(change_flag, 2'h3);
		cyc(4);
		ck({cmp_out_pin_oe_n_q, cmp_out_pin_q}, 2'h1);
		ck(neg_sel_q, 2'h2);
		$display("t_pin done");
	endtask
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	initial begin
		{rst_n, out_pin_enable, idle_mode, power_down_mode, total_power_down} = 0;
		{cmp_enable, neg_sel, int_enable, flag_clear, cmp_raw, power_ctrl_reg_a} = 0;
		cyc(2);
		rst_n = 1;
		t_flag;
		t_pwr;
		t_pin;
		end_of_test;
	end
	initial begin
		#20000;
		err_total = err_total + 1;
		end_of_test;
	end
endmodule // tb_comparator_event_control
bind comparator_event_control cmp_ev_properties chk (.*);
